// [hdl/mpfts_top.sv]
// Overview of operation
// - Frame sync edge is rising when polarity bit is 0, falling when 1
// - Two-bit granularity: 40 ns, 80 ns, 160 ns or 1.0 us per count
// - Early ready bit set: ready as soon as all enabled ports captured
// - Run-mode bit: 0 referenced to frame sync, 1 free-running
// - Capture-event bit: 0 captures at line start, 1 at frame start
// - Hold bit written 1 keeps stamps unchanged and clears ready flag
// - One capture enable bit per port in bits 3 to 0
// - Sixteen-bit line number in two bytes picks capture line, counting from one
// - Free-run frame mode: line number gates when frame start is checked
// - Read-only ready flag plus one valid flag per port
// - Each port stamp readable as upper and lower bytes, reset zero
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "mpfts_consts.svh"
module mpfts_top
	import mpfts_pkg::*;
#(
	parameter int PORTS   = 4,
	parameter int STAMP_W = 16
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	input  wire logic               frame_sync_pin,
	input  wire logic [PORTS-1:0]   rx_line_start,
	input  wire logic [PORTS-1:0]   rx_frame_start,
	output logic                    irq
);
	mpfts_bus_state_t     bus_state_reg;
	logic [7:0]           bus_idx_reg;
	logic [7:0]           cfg_reg;
	logic [7:0]           ctl_reg;
	logic [15:0]          line_reg;
	logic [STAMP_W-1:0]   stamp_reg [PORTS];
	logic [15:0]          lines_reg [PORTS];
	logic [PORTS-1:0]     seen_reg;
	logic [PORTS-1:0]     valid_reg;
	logic [PORTS-1:0]     valid_next;
	logic                 ready_reg;
	logic                 ready_next;
	logic                 armed_reg;
	logic [STAMP_W-1:0]   count_reg;
	logic [`MPFTS_IRQ_W-1:0] irq_sts_reg;
	logic [`MPFTS_IRQ_W-1:0] irq_en_reg;
	logic [`MPFTS_IRQ_W-1:0] irq_ev;
	logic [`MPFTS_IRQ_W-1:0] irq_clr;
	logic [PORTS-1:0]     cap_ev;
	logic [PORTS-1:0]     cap_go;
	logic [PORTS-1:0]     port_en;
	logic                 addr_take;
	logic                 wr_now;
	logic                 hold;
	logic                 free_run;
	logic                 frame_mode;
	logic                 early;
	logic                 sync_edge;
	logic                 round_start;
	logic                 tick;
	logic                 all_cap;

	// Field decode
	assign hold       = ctl_reg[`MPFTS_CTL_HOLD];
	assign port_en    = ctl_reg[`MPFTS_CTL_EN_HI:0];
	assign free_run   = cfg_reg[`MPFTS_CFG_FREE];
	assign frame_mode = cfg_reg[`MPFTS_CFG_EVENT];
	assign early      = cfg_reg[`MPFTS_CFG_EARLY];

	mpfts_sync_edge u_sync (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.pin        (frame_sync_pin),
		.falling    (cfg_reg[`MPFTS_CFG_EDGE]),
		.edge_pulse (sync_edge)
	);

	// sync edge only opens a round when not free-running
	assign round_start = !free_run && sync_edge;

	mpfts_tick_gen u_tick (
		.hclk    (hclk),
		.hresetn (hresetn),
		.restart (round_start),
		.gran    (cfg_reg[`MPFTS_CFG_GRAN_HI:`MPFTS_CFG_GRAN_LO]),
		.tick    (tick)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= '0;
		end else if (round_start) begin
			count_reg <= '0;
		end else if (tick) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	// Round is armed from the first sync edge onward
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_reg <= 1'b0;
		end else if (round_start) begin
			armed_reg <= 1'b1;
		end
	end

	// Per-port line counters and line-reached flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < PORTS; i++) begin
				lines_reg[i] <= `MPFTS_RST_WORD;
			end
			seen_reg <= '0;
		end else begin
			for (int i = 0; i < PORTS; i++) begin
				if (rx_frame_start[i]) begin
					lines_reg[i] <= `MPFTS_RST_WORD;
					seen_reg[i]  <= 1'b0;
				end else if (rx_line_start[i]) begin
					lines_reg[i] <= lines_reg[i] + 16'h0001;
					// line reached opens frame start check
					if (lines_reg[i] + 16'h0001 >= line_reg) begin
						seen_reg[i] <= 1'b1;
					end
				end
			end
		end
	end

	// Capture event selection per port
	always_comb begin
		for (int i = 0; i < PORTS; i++) begin
			if (frame_mode) begin
				cap_ev[i] = rx_frame_start[i] && (!free_run || seen_reg[i]);
			end else begin
				cap_ev[i] = rx_line_start[i]
					&& (lines_reg[i] + 16'h0001 == line_reg);
			end
			// hold blocks capture; enable gates it
			cap_go[i] = cap_ev[i] && port_en[i] && !hold
				&& (free_run || (armed_reg && !valid_reg[i]));
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < PORTS; i++) begin
				stamp_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < PORTS; i++) begin
				if (cap_go[i]) begin
					stamp_reg[i] <= count_reg;
				end
			end
		end
	end

	// valid flags kept while held; new round clears them
	always_comb begin
		valid_next = (round_start && !hold) ? '0 : valid_reg;
		valid_next = valid_next | cap_go;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			valid_reg <= '0;
		end else begin
			valid_reg <= valid_next;
		end
	end

	assign all_cap = (port_en != '0) && ((valid_reg & port_en) == port_en);

	// Ready flag next value
	always_comb begin
		ready_next = ready_reg;
		if (hold || round_start) begin
			ready_next = 1'b0;
		end else if (all_cap && (early || tick)) begin
			// early ready; normal ready on next tick
			ready_next = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= ready_next;
		end
	end

	// Interrupt sources
	assign irq_ev = {cap_go, ready_next && !ready_reg};

	// Sticky status; a new event wins over a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_sts_reg <= '0;
		end else begin
			irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_ev;
		end
	end

	assign irq = |(irq_sts_reg & irq_en_reg);

	// Bus address phase accepted
	assign addr_take = hsel && htrans[1] && hready;
	assign wr_now    = (bus_state_reg == MPFTS_BUS_WRITE);
	assign irq_clr   = (wr_now && bus_idx_reg == `MPFTS_IDX_IRQ_CLEAR)
		? hwdata[`MPFTS_IRQ_W-1:0] : '0;

	// Bus phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state_reg <= MPFTS_BUS_IDLE;
			bus_idx_reg   <= 8'h00;
		end else if (bus_state_reg == MPFTS_BUS_RDWAIT) begin
			bus_state_reg <= MPFTS_BUS_RDDONE;
		end else if (addr_take) begin
			bus_state_reg <= hwrite ? MPFTS_BUS_WRITE : MPFTS_BUS_RDWAIT;
			bus_idx_reg   <= haddr[9:2];
		end else begin
			bus_state_reg <= MPFTS_BUS_IDLE;
		end
	end

	// Reads insert one wait state so a preceding write is seen
	assign hreadyout = (bus_state_reg != MPFTS_BUS_RDWAIT);
	assign hresp     = 1'b0;

	// Software-written registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg    <= `MPFTS_RST_BYTE;
			ctl_reg    <= `MPFTS_RST_BYTE;
			line_reg   <= `MPFTS_RST_WORD;
			irq_en_reg <= '0;
		end else if (wr_now) begin
			unique case (bus_idx_reg)
				`MPFTS_IDX_CONFIG:     cfg_reg <= hwdata[7:0] & `MPFTS_CFG_MASK;
				`MPFTS_IDX_CONTROL:    ctl_reg <= hwdata[7:0] & `MPFTS_CTL_MASK;
				`MPFTS_IDX_LINE_UPPER: line_reg[15:8] <= hwdata[7:0];
				`MPFTS_IDX_LINE_LOWER: line_reg[7:0] <= hwdata[7:0];
				`MPFTS_IDX_IRQ_ENABLE: irq_en_reg <= hwdata[`MPFTS_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Read value for a register index
	function automatic logic [7:0] read_byte(input logic [7:0] idx);
		logic [7:0] off;
		off = idx - `MPFTS_IDX_STAMP_BASE;
		read_byte = 8'h00;
		if (idx >= `MPFTS_IDX_STAMP_BASE && idx <= `MPFTS_IDX_STAMP_LAST) begin
			// stamp upper at even, lower at odd index
			read_byte = off[0] ? stamp_reg[off[2:1]][7:0]
				: stamp_reg[off[2:1]][15:8];
		end else begin
			unique case (idx)
				`MPFTS_IDX_CONFIG:     read_byte = cfg_reg;
				`MPFTS_IDX_CONTROL:    read_byte = ctl_reg;
				`MPFTS_IDX_LINE_UPPER: read_byte = line_reg[15:8];
				`MPFTS_IDX_LINE_LOWER: read_byte = line_reg[7:0];
				`MPFTS_IDX_STATUS:     read_byte = {3'h0, ready_reg, valid_reg};
				`MPFTS_IDX_IRQ_STATUS: read_byte = {3'h0, irq_sts_reg};
				`MPFTS_IDX_IRQ_ENABLE: read_byte = {3'h0, irq_en_reg};
				default:               read_byte = 8'h00;
			endcase
		end
	endfunction

	// Read data loaded during the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (bus_state_reg == MPFTS_BUS_RDWAIT) begin
			hrdata <= {24'h00_0000, read_byte(bus_idx_reg)};
		end
	end
endmodule

// [hdl/mpfts_consts.svh]
`ifndef MPFTS_CONSTS_SVH
`define MPFTS_CONSTS_SVH
// Register indices; byte address is four times the index
`define MPFTS_IDX_CONFIG     8'h25
`define MPFTS_IDX_CONTROL    8'h26
`define MPFTS_IDX_LINE_UPPER 8'h27
`define MPFTS_IDX_LINE_LOWER 8'h28
`define MPFTS_IDX_STATUS     8'h29
`define MPFTS_IDX_STAMP_BASE 8'h2A
`define MPFTS_IDX_STAMP_LAST 8'h31
`define MPFTS_IDX_IRQ_STATUS 8'h40
`define MPFTS_IDX_IRQ_CLEAR  8'h41
`define MPFTS_IDX_IRQ_ENABLE 8'h42
// Configuration fields
`define MPFTS_CFG_MASK       8'h7B
`define MPFTS_CFG_EDGE       6
`define MPFTS_CFG_GRAN_HI    5
`define MPFTS_CFG_GRAN_LO    4
`define MPFTS_CFG_EARLY      3
`define MPFTS_CFG_FREE       1
`define MPFTS_CFG_EVENT      0
// Control fields
`define MPFTS_CTL_MASK       8'h1F
`define MPFTS_CTL_HOLD       4
`define MPFTS_CTL_EN_HI      3
// Status fields
`define MPFTS_STS_READY      4
// Interrupt layout: bit 0 ready, bits 4:1 per-port capture
`define MPFTS_IRQ_W          5
`define MPFTS_IRQ_READY      0
`define MPFTS_IRQ_PORT_LO    1
// Reset values
`define MPFTS_RST_BYTE       8'h00
`define MPFTS_RST_WORD       16'h0000
// Timing: clock period and count intervals in ns
`define MPFTS_CLK_NS         4
`define MPFTS_RES0_NS        40
`define MPFTS_RES1_NS        80
`define MPFTS_RES2_NS        160
`define MPFTS_RES3_NS        1000
`define MPFTS_RES0_CYC       (`MPFTS_RES0_NS / `MPFTS_CLK_NS)
`define MPFTS_RES1_CYC       (`MPFTS_RES1_NS / `MPFTS_CLK_NS)
`define MPFTS_RES2_CYC       (`MPFTS_RES2_NS / `MPFTS_CLK_NS)
`define MPFTS_RES3_CYC       (`MPFTS_RES3_NS / `MPFTS_CLK_NS)
`endif

// [hdl/mpfts_pkg.sv]
package mpfts_pkg;
	// Bus slave phase tracking
	typedef enum logic [1:0] {
		MPFTS_BUS_IDLE,
		MPFTS_BUS_WRITE,
		MPFTS_BUS_RDWAIT,
		MPFTS_BUS_RDDONE
	} mpfts_bus_state_t;
	// Count granularity selector
	typedef logic [1:0] mpfts_gran_t;
endpackage

// [hdl/mpfts_tick_gen.sv]
`timescale 1ns/1ps
`include "mpfts_consts.svh"
module mpfts_tick_gen
	import mpfts_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        restart,
	input  wire mpfts_gran_t gran,
	output logic             tick
);
	logic [7:0] left_reg;

	// Cycles per count for each granularity
	function automatic logic [7:0] interval(input mpfts_gran_t g);
		unique case (g)
			2'b00: interval = 8'(`MPFTS_RES0_CYC);
			2'b01: interval = 8'(`MPFTS_RES1_CYC);
			2'b10: interval = 8'(`MPFTS_RES2_CYC);
			2'b11: interval = 8'(`MPFTS_RES3_CYC);
		endcase
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			left_reg <= 8'h00;
			tick     <= 1'b0;
		end else if (restart || left_reg == 8'h00) begin
			left_reg <= interval(gran) - 8'h01;
			tick     <= !restart;
		end else begin
			left_reg <= left_reg - 8'h01;
			tick     <= 1'b0;
		end
	end
endmodule

// [hdl/mpfts_sync_edge.sv]
`timescale 1ns/1ps
module mpfts_sync_edge (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic pin,
	input  wire logic falling,
	output logic      edge_pulse
);
	logic ff1_reg;
	logic ff2_reg;
	logic ff3_reg;
	logic settled_reg;

	// Three-stage synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ff1_reg <= 1'b0;
			ff2_reg <= 1'b0;
			ff3_reg <= 1'b0;
		end else begin
			ff1_reg <= pin;
			ff2_reg <= ff1_reg;
			ff3_reg <= ff2_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			settled_reg <= 1'b0;
			edge_pulse  <= 1'b0;
		end else if (ff2_reg == ff3_reg && ff3_reg != settled_reg) begin
			settled_reg <= ff3_reg;
			edge_pulse  <= (ff3_reg != falling);
		end else begin
			edge_pulse  <= 1'b0;
		end
	end
endmodule

// [verification/mpfts_top_sva.sv]
`timescale 1ns/1ps
module mpfts_top_sva #(
	parameter int PORTS   = 4,
	parameter int STAMP_W = 16
) (
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic             hsel,
	input wire logic [31:0]      haddr,
	input wire logic [1:0]       htrans,
	input wire logic             hwrite,
	input wire logic [2:0]       hsize,
	input wire logic [31:0]      hwdata,
	input wire logic             hready,
	input wire logic             hreadyout,
	input wire logic             hresp,
	input wire logic [31:0]      hrdata,
	input wire logic             frame_sync_pin,
	input wire logic [PORTS-1:0] rx_line_start,
	input wire logic [PORTS-1:0] rx_frame_start,
	input wire logic             irq
);
	logic       wr_dp;
	logic [8:0] quiet_cnt;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Write data phase flag and cycles since the last possible interrupt cause
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_dp     <= 1'b0;
			quiet_cnt <= 9'h1FF;
		end else begin
			wr_dp <= hsel && htrans[1] && hready && hwrite;
			if (wr_dp || (|rx_line_start) || (|rx_frame_start))
				quiet_cnt <= 9'h000;
			else if (quiet_cnt != 9'h1FF)
				quiet_cnt <= quiet_cnt + 9'h001;
		end
	end
	sequence rd_req;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	read_wait_a: assert property (rd_req |=> one_wait)
		else $error("read wait state wrong");
	write_fast_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
		else $error("write stalled");
	short_wait_a: assert property (!hreadyout |=> hreadyout)
		else $error("wait longer than one cycle");
	upper_zero_a: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
		else $error("read data changed outside a read");
	irq_cause_a: assert property ($rose(irq) |-> quiet_cnt < 9'h12C)
		else $error("interrupt rose without cause");
	irq_clear_a: assert property ($fell(irq) |-> $past(wr_dp))
		else $error("interrupt fell without a write");
endmodule

// [verification/mpfts_video_model.sv]
`timescale 1ns/1ps
module mpfts_video_model (
	input  wire logic  hclk,
	output logic       frame_sync_pin,
	output logic [3:0] rx_line_start,
	output logic [3:0] rx_frame_start
);
	initial begin
		frame_sync_pin = 1'b0;
		rx_line_start  = 4'h0;
		rx_frame_start = 4'h0;
	end
	// Sync pin level change, then settle time for the synchroniser
	task automatic sync_level(input logic v);
		@(posedge hclk);
		frame_sync_pin <= v;
		repeat (10) @(posedge hclk);
	endtask
	// same-clock pulses: one-cycle frame or line start on chosen ports
	task automatic pulse(input logic f, input logic [3:0] m);
		@(posedge hclk);
		if (f)
			rx_frame_start <= m;
		else
			rx_line_start <= m;
		@(posedge hclk);
		rx_frame_start <= 4'h0;
		rx_line_start  <= 4'h0;
	endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
`include "mpfts_consts.svh"
module tb_top;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fs_pin, irq;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  line_ev, frame_ev;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:0] s0, s2;
	int          fails, check_count;
	int          cy [4] = '{`MPFTS_RES0_CYC, `MPFTS_RES1_CYC, `MPFTS_RES2_CYC, `MPFTS_RES3_CYC};
	mpfts_top mpfts_top_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frame_sync_pin(fs_pin),
		.rx_line_start(line_ev), .rx_frame_start(frame_ev), .irq(irq));
	mpfts_video_model mpfts_video_model_inst (
		.hclk(hclk), .frame_sync_pin(fs_pin), .rx_line_start(line_ev),
		.rx_frame_start(frame_ev));
	// Free-running bus clock
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	task automatic finish_test;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One AHB-Lite single word transfer
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {22'h000000, idx, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask
	task automatic st(input logic [7:0] idx, output logic [15:0] v);
		bus(1'b0, idx, 8'h00);
		v[15:8] = rd[7:0];
		bus(1'b0, idx + 8'h01, 8'h00);
		v[7:0] = rd[7:0];
	endtask
	task automatic irqc(input logic exp);
		#1;
		chk(32'(irq), 32'(exp));
	endtask
	task automatic ev(input logic f, input logic [3:0] m);
		mpfts_video_model_inst.pulse(f, m);
	endtask
	task automatic lv(input logic v);
		mpfts_video_model_inst.sync_level(v);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 15; i++)
			rdc(8'h25 + 8'(i), 32'h0);
		rdc(8'h40, 32'h0);
		rdc(8'h42, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_regs;
		bus(1'b1, 8'h25, 8'hFF);
		rdc(8'h25, 32'h7B);
		bus(1'b1, 8'h26, 8'hFF);
		rdc(8'h26, 32'h1F);
		bus(1'b1, 8'h27, 8'hA5);
		rdc(8'h27, 32'hA5);
		bus(1'b1, 8'h50, 8'hFF);
		rdc(8'h50, 32'h0);
		bus(1'b1, 8'h25, 8'h00);
		bus(1'b1, 8'h26, 8'h05);
		bus(1'b1, 8'h27, 8'h00);
		bus(1'b1, 8'h28, 8'h02);
		$display("test registers done");
	endtask
	task automatic t_gran;
		logic p;
		for (int g = 0; g < 4; g++) begin
			p = g[0];
			bus(1'b1, 8'h25, {1'b0, p, 2'(g), 4'h0});
			lv(p);
			lv(!p);
			ev(1'b1, 4'hF);
			ev(1'b0, 4'hF);
			rdc(8'h29, 32'h00);
			ev(1'b0, 4'h1);
			repeat (998) @(posedge hclk);
			ev(1'b0, 4'h6);
			repeat (300) @(posedge hclk);
			rdc(8'h29, 32'h15);
			st(8'h2A, s0);
			st(8'h2E, s2);
			chk(32'(s2 - s0), 32'(1000 / cy[g]));
			lv(p);
			rdc(8'h29, 32'h15);
		end
		$display("test granularity done");
	endtask
	task automatic t_hold;
		bus(1'b1, 8'h26, 8'h15);
		rdc(8'h29, 32'h05);
		lv(1'b0);
		ev(1'b1, 4'hF);
		ev(1'b0, 4'hF);
		ev(1'b0, 4'hF);
		rdc(8'h29, 32'h05);
		st(8'h2A, s2);
		chk(32'(s2), 32'(s0));
		bus(1'b1, 8'h26, 8'h05);
		lv(1'b1);
		lv(1'b0);
		ev(1'b1, 4'hF);
		ev(1'b0, 4'h1);
		ev(1'b0, 4'h1);
		repeat (300) @(posedge hclk);
		rdc(8'h29, 32'h01);
		$display("test hold done");
	endtask
	task automatic t_early;
		for (int n = 0; n < 2; n++) begin
			bus(1'b1, 8'h26, 8'h01);
			bus(1'b1, 8'h25, (n == 0) ? 8'h38 : 8'h30);
			lv(1'b1);
			repeat (90) @(posedge hclk);
			ev(1'b1, 4'h1);
			ev(1'b0, 4'h1);
			ev(1'b0, 4'h1);
			rdc(8'h29, (n == 0) ? 32'h11 : 32'h01);
			lv(1'b0);
		end
		repeat (300) @(posedge hclk);
		rdc(8'h29, 32'h11);
		$display("test early ready done");
	endtask
	task automatic t_free;
		bus(1'b1, 8'h25, 8'h03);
		ev(1'b1, 4'h1);
		bus(1'b1, 8'h41, 8'h1F);
		bus(1'b1, 8'h42, 8'h02);
		irqc(1'b0);
		ev(1'b1, 4'h1);
		bus(1'b0, 8'h40, 8'h00);
		chk(rd & 32'h2, 32'h0);
		ev(1'b0, 4'h1);
		ev(1'b0, 4'h1);
		ev(1'b1, 4'h1);
		bus(1'b0, 8'h40, 8'h00);
		chk(rd & 32'h2, 32'h2);
		irqc(1'b1);
		bus(1'b1, 8'h42, 8'h00);
		irqc(1'b0);
		bus(1'b1, 8'h42, 8'h02);
		irqc(1'b1);
		bus(1'b1, 8'h41, 8'h02);
		irqc(1'b0);
		$display("test free run done");
	endtask
	// Mid-run reset, then free-run line capture with no sync edge
	task automatic t_rerun;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		irqc(1'b0);
		rdc(8'h29, 32'h00);
		bus(1'b1, 8'h28, 8'h02);
		bus(1'b1, 8'h25, 8'h02);
		bus(1'b1, 8'h26, 8'h01);
		ev(1'b0, 4'h1);
		ev(1'b0, 4'h1);
		bus(1'b0, 8'h29, 8'h00);
		chk(rd & 32'h0F, 32'h01);
		$display("test reset rerun done");
	endtask
	// Reset, then the scenarios in order
	initial begin
		hresetn     = 1'b0;
		hsel        = 1'b0;
		htrans      = 2'h0;
		hwrite      = 1'b0;
		hsize       = 3'h2;
		haddr       = 32'h0;
		hwdata      = 32'h0;
		fails       = 0;
		check_count = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_regs;
		t_gran;
		t_hold;
		t_early;
		t_free;
		t_rerun;
		finish_test;
	end
	// Watchdog against a hung handshake
	initial begin
		#200000;
		fails++;
		finish_test;
	end
endmodule
bind mpfts_top mpfts_top_sva #(.PORTS(PORTS), .STAMP_W(STAMP_W)) mpfts_top_sva_inst (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.frame_sync_pin(frame_sync_pin), .rx_line_start(rx_line_start),
	.rx_frame_start(rx_frame_start), .irq(irq));
